/* hdl/mpg_top.sv */
// Mode decoder, pin router and output-bank gating for a three-PLL clock generator.
// Assumes board pins are asynchronous; the PLL, dividers and serial engines are outside.
`timescale 1ns/1ps
`default_nettype none
module mpg_top #(
   parameter int NUM_BANK = mpg_pkg::NUM_BANK,
   parameter int QDIV_W = mpg_pkg::QDIV_W,
   parameter int RELOCK_CYCLES = mpg_pkg::RELOCK_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [5:0] i_gp_in,
   input wire logic [1:0] i_mode_pin_lvl,
   input wire logic i_shutdown_oe_pin,
   input wire logic i_manual_freq_select,
   input wire logic [5:0] i_gp_in_enable,
   input wire logic i_shutdown_polarity,
   input wire logic i_global_off_function,
   input wire logic [NUM_BANK-1:0] i_bank_oe_mask,
   input wire logic [2*NUM_BANK-1:0] i_bank_disable_level,
   input wire logic [NUM_BANK-1:0] i_bank_suspend_mask,
   input wire logic [2:0] i_pll_suspend_mask,
   input wire logic [3*NUM_BANK-1:0] i_bank_pll_src,
   input wire logic [NUM_BANK-1:0] i_bank_invert,
   input wire logic [11:0] i_out_div_select,
   input wire logic [2*QDIV_W*NUM_BANK-1:0] i_post_div_sets,
   input wire logic i_primary_ref_select,
   input wire logic [2:0] i_pll_locked,
   input wire logic i_lock_lost_flag,
   input wire logic i_ref_lost_flag,
   input wire logic i_scan_tdo,
   output logic [1:0] o_mode,
   output logic [1:0] o_pll0_sel,
   output logic [1:0] o_pll1_sel,
   output logic [1:0] o_pll2_sel,
   output logic [2:0] o_pll0_sel8,
   output logic [NUM_BANK-1:0] o_bank_div_set,
   output logic [QDIV_W*NUM_BANK-1:0] o_post_divider_value,
   output logic o_serial_data_pin,
   output logic o_serial_clock,
   output logic o_scan_tck,
   output logic o_scan_tms,
   output logic o_scan_trst,
   output logic o_suspend,
   output logic o_ref_select,
   output logic o_prog_allowed,
   output logic o_osc_off,
   output logic [2:0] o_pll_power_down,
   output logic [2:0] o_pll_lock_valid,
   output logic [NUM_BANK-1:0] o_bank_power_down,
   output logic [NUM_BANK-1:0] o_bank_out_en,
   output logic [NUM_BANK-1:0] o_bank_level,
   output logic [NUM_BANK-1:0] o_bank_level_inv,
   output logic o_gp_out_0,
   output logic o_gp_out_1
);
   mpg_sync_if sif ();
   assign sif.raw = i_gp_in;
   assign sif.raw_mode = i_mode_pin_lvl;
   assign sif.raw_shut = i_shutdown_oe_pin;

   mpg_sync u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .sif(sif)
   );

   // Selectors for eight- and four-way configuration sets
   function automatic logic [1:0] pair_sel(input logic [5:0] v, input int idx);
      pair_sel = {v[2*idx+1], v[2*idx]};
   endfunction : pair_sel

   logic [5:0] latch_ff;
   logic pwr_up_ff;
   logic [1:0] mode_ff;
   logic shut_act;
   logic prog_mode;
   logic [5:0] gp_eff;
   logic [5:0] sel_src;
   logic [1:0] nxt_mode;

   // Shutdown pin polarity and function
   assign shut_act = sif.shut ^ i_shutdown_polarity;

   // Mode decode; shutdown parks the mode pin at its middle level
   always_comb begin
      if (shut_act && i_global_off_function) begin
         nxt_mode = i_manual_freq_select ? mpg_pkg::MPG_MODE_SINGLE
            : mpg_pkg::MPG_MODE_PER_PLL;
      end else if (sif.mode_lvl == mpg_pkg::MPG_PIN_HIGH) begin
         nxt_mode = mpg_pkg::MPG_MODE_SERIAL;
      end else if (sif.mode_lvl == mpg_pkg::MPG_PIN_LOW) begin
         nxt_mode = mpg_pkg::MPG_MODE_SCAN;
      end else begin
         nxt_mode = i_manual_freq_select ? mpg_pkg::MPG_MODE_SINGLE
            : mpg_pkg::MPG_MODE_PER_PLL;
      end
   end

   assign prog_mode = (mode_ff == mpg_pkg::MPG_MODE_SERIAL)
      || (mode_ff == mpg_pkg::MPG_MODE_SCAN);

   // Reset behaves as per-PLL mode until the synchroniser has settled
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         mode_ff <= mpg_pkg::MPG_MODE_PER_PLL;
         pwr_up_ff <= 1'b1;
         latch_ff <= mpg_pkg::RST_GP_IN;
      end else if (i_ce) begin
         mode_ff <= pwr_up_ff ? mpg_pkg::MPG_MODE_PER_PLL : nxt_mode;
         pwr_up_ff <= 1'b0;
         // Latch ignores enables and mode; input 5 is never latched
         if (pwr_up_ff) begin
            latch_ff <= {1'b0, sif.gp[4:0]};
         end
      end
   end

   // Enable masking; disabled inputs read low
   assign gp_eff = sif.gp & i_gp_in_enable;
   // Manual modes follow live pins, programming modes hold the latch
   assign sel_src = prog_mode ? latch_ff : gp_eff;

   logic [1:0] nxt_sel0;
   logic [1:0] nxt_sel1;
   logic [1:0] nxt_sel2;
   logic [2:0] nxt_sel8;
   always_comb begin
      nxt_sel0 = pair_sel(sel_src, 0);
      nxt_sel1 = pair_sel(sel_src, 1);
      nxt_sel2 = pair_sel(sel_src, 2);
      nxt_sel8 = sel_src[2:0];
      if (mode_ff == mpg_pkg::MPG_MODE_SINGLE) begin
         // Single-PLL mode keeps PLL1 and PLL2 on their default set
         nxt_sel1 = mpg_pkg::RST_SEL;
         nxt_sel2 = mpg_pkg::RST_SEL;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pll0_sel <= mpg_pkg::RST_SEL;
         o_pll1_sel <= mpg_pkg::RST_SEL;
         o_pll2_sel <= mpg_pkg::RST_SEL;
         o_pll0_sel8 <= mpg_pkg::RST_SEL8;
         o_mode <= mpg_pkg::MPG_MODE_PER_PLL;
      end else if (i_ce) begin
         o_pll0_sel <= nxt_sel0;
         o_pll1_sel <= nxt_sel1;
         o_pll2_sel <= nxt_sel2;
         o_pll0_sel8 <= nxt_sel8;
         o_mode <= mode_ff;
      end
   end

   // Divider set per bank from the active configuration of its PLL
   logic [NUM_BANK-1:0] nxt_div_set;
   logic [QDIV_W*NUM_BANK-1:0] nxt_qdiv;
   always_comb begin
      nxt_div_set = '0;
      nxt_qdiv = '0;
      for (int b = 0; b < NUM_BANK; b++) begin
         logic [1:0] src;
         logic [3:0] bit_idx;
         src = i_bank_pll_src[3*b +: 2];
         bit_idx = 4'h0;
         if (mode_ff == mpg_pkg::MPG_MODE_SINGLE && src == 2'h0) begin
            // Configs 4..7 borrow slots 2,3 of PLL1 and PLL2
            bit_idx = nxt_sel8[2] ? {nxt_sel8[1], ~nxt_sel8[1], 1'b1, nxt_sel8[0]}
               : {2'b00, nxt_sel8[1:0]};
         end else if (src == 2'h0) begin
            bit_idx = {2'b00, nxt_sel0};
         end else if (src == 2'h1) begin
            bit_idx = {2'b01, nxt_sel1};
         end else begin
            bit_idx = {2'b10, nxt_sel2};
         end
         nxt_div_set[b] = i_out_div_select[bit_idx];
         nxt_qdiv[QDIV_W*b +: QDIV_W] =
            i_post_div_sets[(2*b + nxt_div_set[b])*QDIV_W +: QDIV_W];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_bank_div_set <= mpg_pkg::RST_BANK;
         o_post_divider_value <= '0;
      end else if (i_ce) begin
         o_bank_div_set <= nxt_div_set;
         o_post_divider_value <= nxt_qdiv;
      end
   end

   // Pin routing; inputs 3 and 5 obey their enables, serial pins do not
   logic susp_in;
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_serial_data_pin <= 1'b0;
         o_serial_clock <= 1'b0;
         o_scan_tck <= 1'b0;
         o_scan_tms <= 1'b0;
         o_scan_trst <= 1'b0;
         o_suspend <= 1'b0;
         o_ref_select <= 1'b0;
         o_prog_allowed <= 1'b0;
         o_osc_off <= 1'b0;
      end else if (i_ce) begin
         o_serial_data_pin <= prog_mode & sif.gp[0];
         o_serial_clock <= (mode_ff == mpg_pkg::MPG_MODE_SERIAL) & sif.gp[1];
         o_scan_tck <= (mode_ff == mpg_pkg::MPG_MODE_SCAN) & sif.gp[1];
         o_scan_tms <= (mode_ff == mpg_pkg::MPG_MODE_SCAN) & sif.gp[2];
         o_scan_trst <= (mode_ff == mpg_pkg::MPG_MODE_SCAN) & sif.gp[4];
         o_suspend <= susp_in;
         // Per-PLL mode takes i_primary_ref_select; the other modes follow enabled input 5
         o_ref_select <= (mode_ff == mpg_pkg::MPG_MODE_PER_PLL)
            ? i_primary_ref_select : gp_eff[5];
         o_prog_allowed <= prog_mode & ~(shut_act & i_global_off_function);
         o_osc_off <= shut_act & i_global_off_function;
      end
   end

   // Suspend is input 3 except in per-PLL mode where it is a selector
   assign susp_in = (mode_ff != mpg_pkg::MPG_MODE_PER_PLL) & gp_eff[3];

   // Output gating
   logic glob_off;
   logic oe_act;
   logic [2:0] pll_down;
   assign glob_off = shut_act & i_global_off_function;
   assign oe_act = shut_act & ~i_global_off_function;
   // Shutdown leaves PLLs running
   assign pll_down = (susp_in & ~glob_off) ? i_pll_suspend_mask : 3'h0;

   logic [NUM_BANK-1:0] nxt_pd;
   logic [NUM_BANK-1:0] nxt_oe;
   logic [NUM_BANK-1:0] nxt_lvl;
   always_comb begin
      nxt_pd = '0;
      nxt_oe = '0;
      nxt_lvl = '0;
      for (int b = 0; b < NUM_BANK; b++) begin
         logic pll_off;
         logic [1:0] dl;
         pll_off = pll_down[i_bank_pll_src[3*b +: 2]];
         dl = i_bank_disable_level[2*b +: 2];
         nxt_pd[b] = ~glob_off & (pll_off | (susp_in & i_bank_suspend_mask[b]));
         nxt_oe[b] = 1'b1;
         nxt_lvl[b] = 1'b0;
         if (glob_off) begin
            nxt_oe[b] = 1'b0;
         end else if (nxt_pd[b]) begin
            nxt_oe[b] = 1'b0;
         end else if (oe_act && i_bank_oe_mask[b]) begin
            nxt_oe[b] = (dl == mpg_pkg::DIS_LOW) || (dl == mpg_pkg::DIS_HIGH);
            nxt_lvl[b] = dl == mpg_pkg::DIS_HIGH;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_bank_power_down <= mpg_pkg::RST_BANK;
         o_bank_out_en <= mpg_pkg::RST_BANK;
         o_bank_level <= mpg_pkg::RST_BANK;
         o_bank_level_inv <= mpg_pkg::RST_BANK;
         o_pll_power_down <= 3'h0;
      end else if (i_ce) begin
         o_bank_power_down <= nxt_pd;
         o_bank_out_en <= nxt_oe;
         o_bank_level <= nxt_lvl;
         o_bank_level_inv <= ~nxt_lvl ^ i_bank_invert;
         o_pll_power_down <= pll_down;
      end
   end

   // Relock wait after suspend; shutdown does not touch this
   logic [2:0] relock_pend_ff;
   logic [2:0] nxt_lock_valid;
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         nxt_lock_valid[p] = i_pll_locked[p] & ~pll_down[p] & ~relock_pend_ff[p];
      end
   end
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         relock_pend_ff <= 3'h0;
         o_pll_lock_valid <= 3'h0;
      end else if (i_ce) begin
         for (int p = 0; p < 3; p++) begin
            if (pll_down[p]) begin
               relock_pend_ff[p] <= 1'b1;
            end else if (i_pll_locked[p]) begin
               relock_pend_ff[p] <= 1'b0;
            end
         end
         o_pll_lock_valid <= nxt_lock_valid;
      end
   end

   // Status outputs
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_gp_out_0 <= 1'b0;
         o_gp_out_1 <= 1'b0;
      end else if (i_ce) begin
         o_gp_out_0 <= (mode_ff == mpg_pkg::MPG_MODE_SCAN) ? i_scan_tdo
            : i_lock_lost_flag;
         o_gp_out_1 <= i_ref_lost_flag;
      end
   end
endmodule : mpg_top
`default_nettype wire

/* shared/mpg_pkg.sv */
// Package for the multipurpose pin mode decoder and output gating block.
// Assumes a single 100 MHz clock domain; all pins arrive asynchronously.
package mpg_pkg;
   localparam int NUM_GPIN = 6;
   localparam int NUM_PLL = 3;
   localparam int NUM_BANK = 6;
   localparam int CFG_PER_PLL = 4;
   localparam int QDIV_W = 10;
   localparam int SYNC_STAGES = 2;
   // Printed register offsets, kept for reference by software models
   localparam logic [7:0] OFS_MANUAL_FREQ = 8'h04;
   localparam logic [7:0] OFS_GP_IN_ENABLE = 8'h06;
   localparam logic [7:0] OFS_SHUTDOWN_CTRL = 8'h1C;
   localparam logic [7:0] OFS_BANK_SUSPEND = 8'h1D;
   localparam logic [7:0] OFS_PLL_SUSPEND = 8'h1E;
   // Values after reset
   localparam logic [5:0] RST_GP_IN = 6'h00;
   localparam logic [1:0] RST_SEL = 2'h0;
   localparam logic [2:0] RST_SEL8 = 3'h0;
   localparam logic [NUM_BANK-1:0] RST_BANK = 6'h00;
   // Lock reacquire count after a PLL leaves suspend
   localparam int RELOCK_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RELOCK_CYCLES = (RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Bank disable level encodings
   localparam logic [1:0] DIS_LOW = 2'h2;
   localparam logic [1:0] DIS_HIGH = 2'h3;

   // Pin level encoding for the three-level mode pin
   typedef enum logic [1:0] {
      MPG_PIN_LOW = 2'h0,
      MPG_PIN_MID = 2'h1,
      MPG_PIN_HIGH = 2'h3
   } mpg_pinlvl_t;

   // Operating modes, Gray coded
   typedef enum logic [1:0] {
      MPG_MODE_PER_PLL = 2'h0,
      MPG_MODE_SINGLE = 2'h1,
      MPG_MODE_SERIAL = 2'h3,
      MPG_MODE_SCAN = 2'h2
   } mpg_mode_t;
endpackage : mpg_pkg

/* shared/mpg_sync_if.sv */
// Carrier between the top module and its input synchroniser.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mpg_sync_if;
   logic [mpg_pkg::NUM_GPIN-1:0] raw;
   logic [1:0] raw_mode;
   logic raw_shut;
   logic [mpg_pkg::NUM_GPIN-1:0] gp;
   logic [1:0] mode_lvl;
   logic shut;
   modport prod (input raw, input raw_mode, input raw_shut, output gp, output mode_lvl,
      output shut);
   modport cons (output raw, output raw_mode, output raw_shut, input gp, input mode_lvl,
      input shut);
endinterface : mpg_sync_if
`default_nettype wire

/* hdl/mpg_sync.sv */
// Two-stage synchroniser for every asynchronous pin of the block.
// Assumes clock enable freezes it with the rest of the design.
`timescale 1ns/1ps
`default_nettype none
module mpg_sync (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_ce,
   mpg_sync_if.prod sif
);
   logic [8:0] meta_ff;
   logic [8:0] sync_ff;

   // First stage feeds only the second stage; reset keeps them sampling, so the
   // power-up latch on the first edge after reset sees real pin levels
   always_ff @(posedge i_clock) begin
      if (i_ce || i_rst) begin
         meta_ff <= {sif.raw_shut, sif.raw_mode, sif.raw};
         sync_ff <= meta_ff;
      end
   end

   assign sif.gp = sync_ff[5:0];
   assign sif.mode_lvl = sync_ff[7:6];
   assign sif.shut = sync_ff[8];
endmodule : mpg_sync
`default_nettype wire

/* tb/mpg_top_properties.sv */
// Concurrent checks on the ports of the pin mode and output gating top.
// Assumes only the pins move while clock enable is low.
`timescale 1ns/1ps
`default_nettype none
module mpg_props #(
   parameter int NUM_BANK = 6
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_ref_lost_flag,
   input wire logic i_lock_lost_flag,
   input wire logic i_scan_tdo,
   input wire logic i_global_off_function,
   input wire logic i_shutdown_oe_pin,
   input wire logic i_shutdown_polarity,
   input wire logic [2:0] i_pll_suspend_mask,
   input wire logic [NUM_BANK-1:0] i_bank_oe_mask,
   input wire logic [1:0] o_mode,
   input wire logic o_gp_out_0,
   input wire logic o_gp_out_1,
   input wire logic o_prog_allowed,
   input wire logic o_osc_off,
   input wire logic o_suspend,
   input wire logic [2:0] o_pll_power_down,
   input wire logic [NUM_BANK-1:0] o_bank_power_down,
   input wire logic [NUM_BANK-1:0] o_bank_out_en
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   chk_ref_flag_out: assert property (
      !$past(i_rst) && $stable(i_ref_lost_flag) |=> o_gp_out_1 == $past(i_ref_lost_flag))
      else $error("gp_out_1 lost the reference flag");
   chk_lock_flag_out: assert property (
      !$past(i_rst) && $stable(i_lock_lost_flag)
      |=> o_mode == 2'h2 || o_gp_out_0 == $past(i_lock_lost_flag))
      else $error("gp_out_0 lost the lock flag");
   chk_scan_data_out: assert property (
      $stable(i_scan_tdo) |=> o_mode != 2'h2 || o_gp_out_0 == $past(i_scan_tdo))
      else $error("gp_out_0 not scan data in scan mode");
   chk_shut_blocks_prog: assert property (
      o_osc_off && $past(o_osc_off) |-> !o_prog_allowed && !o_mode[1])
      else $error("programming open during shutdown");
   chk_shut_tristates: assert property (
      o_osc_off |-> o_bank_out_en == '0 && o_pll_power_down == 3'h0)
      else $error("outputs driven or pll off in shutdown");
   // The pin reaches the gating three edges late, after both sync stages
   chk_shut_cause: assert property (
      o_osc_off |-> $past(i_global_off_function)
      && $past(i_shutdown_oe_pin, 3) != $past(i_shutdown_polarity))
      else $error("shutdown without active pin and global off");
   chk_pll_mask_only: assert property (
      (o_pll_power_down & ~$past(i_pll_suspend_mask)) == 3'h0)
      else $error("unmasked pll powered down");
   chk_bank_pd_off: assert property (
      (o_bank_power_down & o_bank_out_en) == '0)
      else $error("powered down bank still driving");
   chk_oe_unmasked: assert property (
      !$past(i_rst) && !o_osc_off
      |-> (~$past(i_bank_oe_mask) & ~o_bank_power_down & ~o_bank_out_en) == '0)
      else $error("unmasked bank disabled");
   chk_no_susp_perpll: assert property (
      o_mode == 2'h0 |-> !o_suspend)
      else $error("suspend active in per-pll mode");
endmodule : mpg_props
`default_nettype wire

/* tb/mpg_board.sv */
// Board model driving the asynchronous selection pins of the block.
// Assumes the bench hands it target levels; the mode pin only takes 00, 01 or 11.
`timescale 1ns/1ps
`default_nettype none
module mpg_board (
   input wire logic i_clock,
   input wire logic i_hold_low,
   input wire logic [5:0] i_want_gp,
   input wire logic [1:0] i_want_mode,
   input wire logic i_want_shut,
   output logic [5:0] o_gp_in,
   output logic [1:0] o_mode_pin_lvl,
   output logic o_shutdown_oe_pin
);
   initial begin
      o_gp_in = 6'h00;
      o_mode_pin_lvl = 2'h1;
      o_shutdown_oe_pin = 1'b0;
   end
   // Targets are taken at the edge and pins move 1 ns later, so no sample races them
   always @(posedge i_clock) begin
      o_gp_in <= #1 (i_hold_low ? 6'h00 : i_want_gp);
      o_mode_pin_lvl <= #1 i_want_mode;
      o_shutdown_oe_pin <= #1 i_want_shut;
   end
endmodule : mpg_board
`default_nettype wire

/* tb/test_multipurpose_pin_mode_and_output_gating.sv */
// Self-checking bench for the pin mode decoder and output gating block.
// Assumes a 100 MHz clock; the board model drives the asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module test_multipurpose_pin_mode_and_output_gating;
   logic i_clock, i_rst, hold_low, want_shut, i_shutdown_oe_pin, i_manual_freq_select;
   logic i_shutdown_polarity, i_global_off_function, i_primary_ref_select;
   logic i_lock_lost_flag, i_ref_lost_flag, i_scan_tdo, o_serial_data_pin, o_serial_clock;
   logic o_scan_tck, o_scan_tms, o_scan_trst, o_suspend, o_ref_select, o_prog_allowed;
   logic o_osc_off, o_gp_out_0, o_gp_out_1;
   logic [1:0] want_mode, i_mode_pin_lvl, o_mode, o_pll0_sel, o_pll1_sel, o_pll2_sel;
   logic [5:0] want_gp, i_gp_in, i_gp_in_enable, i_bank_oe_mask, i_bank_suspend_mask;
   logic [5:0] i_bank_invert, o_bank_div_set, o_bank_power_down, o_bank_out_en, o_bank_level;
   logic [11:0] i_bank_disable_level, i_out_div_select;
   logic [2:0] i_pll_suspend_mask, i_pll_locked, o_pll0_sel8, o_pll_power_down;
   logic [17:0] i_bank_pll_src;
   logic [119:0] i_post_div_sets;
   logic [59:0] o_post_divider_value;
   logic [4:0] lat;
   logic [5:0] o_bank_level_inv;
   logic [2:0] o_pll_lock_valid;
   logic [15:0] frozen;
   logic ce;
   int n_errors, check_count, seed, k;
   mpg_top u_mpg_top (.i_clock, .i_rst, .i_ce(ce), .i_gp_in, .i_mode_pin_lvl,
      .i_shutdown_oe_pin, .i_manual_freq_select, .i_gp_in_enable, .i_shutdown_polarity,
      .i_global_off_function, .i_bank_oe_mask, .i_bank_disable_level, .i_bank_suspend_mask,
      .i_pll_suspend_mask, .i_bank_pll_src, .i_bank_invert, .i_out_div_select,
      .i_post_div_sets, .i_primary_ref_select, .i_pll_locked, .i_lock_lost_flag,
      .i_ref_lost_flag, .i_scan_tdo, .o_mode, .o_pll0_sel, .o_pll1_sel, .o_pll2_sel,
      .o_pll0_sel8, .o_bank_div_set, .o_post_divider_value, .o_serial_data_pin,
      .o_serial_clock, .o_scan_tck, .o_scan_tms, .o_scan_trst, .o_suspend, .o_ref_select,
      .o_prog_allowed, .o_osc_off, .o_pll_power_down, .o_pll_lock_valid,
      .o_bank_power_down, .o_bank_out_en, .o_bank_level, .o_bank_level_inv,
      .o_gp_out_0, .o_gp_out_1);
   mpg_board u_mpg_board (.i_clock, .i_hold_low(hold_low), .i_want_gp(want_gp),
      .i_want_mode(want_mode), .i_want_shut(want_shut), .o_gp_in(i_gp_in),
      .o_mode_pin_lvl(i_mode_pin_lvl), .o_shutdown_oe_pin(i_shutdown_oe_pin));
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task automatic chk(input logic [59:0] seen, input logic [59:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // Mode mid and high are each drawn twice as often as low, so the per-pll selectors see most traffic
   task automatic randomize_inputs;
      int r;
      r = $unsigned($random(seed)) % 5;
      want_mode = r < 2 ? 2'h1 : r == 2 ? 2'h0 : 2'h3;
      ce = 1'b1;
      want_gp = 6'($random(seed));
      want_shut = 1'($random(seed));
      i_gp_in_enable = r[0] ? 6'h3F : 6'($random(seed));
      i_manual_freq_select = 2'($random(seed)) == 2'h0;
      {i_shutdown_polarity, i_global_off_function, i_primary_ref_select} = 3'($random(seed));
      {i_lock_lost_flag, i_ref_lost_flag, i_scan_tdo, i_pll_locked} = 6'($random(seed));
      {i_bank_oe_mask, i_bank_suspend_mask, i_bank_invert} = 18'($random(seed));
      {i_bank_disable_level, i_out_div_select} = 24'($random(seed));
      i_pll_suspend_mask = 3'($random(seed));
      i_post_div_sets = {$random(seed), $random(seed), $random(seed), 24'($random(seed))};
      for (int b = 0; b < 6; b++) i_bank_pll_src[3*b+:3] = 3'($unsigned($random(seed)) % 3);
   endtask : randomize_inputs
   task automatic check_all;
      logic [1:0] md;
      logic [5:0] eg, eoe, epd, elvl;
      logic act, off, sus, s;
      int p, q;
      act = want_shut ^ i_shutdown_polarity;
      off = act & i_global_off_function;
      md = (off || want_mode == 2'h1) ? {1'b0, i_manual_freq_select} : want_mode | 2'h2;
      eg = want_gp & (i_gp_in_enable | (md == 2'h3 ? 6'h03 : md == 2'h2 ? 6'h17 : 6'h00));
      sus = md != 2'h0 && eg[3];
      // Single-PLL configs 4..7 use slots 2,3 of PLL1 then PLL2
      q = eg[2] ? 4 * (1 + eg[1]) + 2 + eg[0] : eg[1:0];
      elvl = '0;
      chk(o_mode, md);
      chk(o_prog_allowed, md[1]);
      chk(o_osc_off, off);
      chk(o_gp_out_0, md == 2'h2 ? i_scan_tdo : i_lock_lost_flag);
      chk(o_gp_out_1, i_ref_lost_flag);
      chk(o_pll_power_down, off ? 3'h0 : {3{sus}} & i_pll_suspend_mask);
      chk(o_pll_lock_valid, 3'(i_pll_locked & ~(off ? 3'h0 : {3{sus}} & i_pll_suspend_mask)));
      if (md != 2'h0) chk(o_suspend, sus);
      if (md == 2'h0) chk({o_pll2_sel, o_pll1_sel, o_pll0_sel}, eg);
      if (md == 2'h0) chk(o_ref_select, i_primary_ref_select);
      if (md == 2'h1) chk(o_pll0_sel8, eg[2:0]);
      if (md[1]) chk({o_pll2_sel, o_pll1_sel, o_pll0_sel}, {1'b0, lat});
      if (md[1]) chk(o_ref_select, eg[5]);
      if (md == 2'h3) chk({o_serial_clock, o_serial_data_pin}, want_gp[1:0]);
      if (md == 2'h2) chk({o_scan_trst, o_scan_tms, o_scan_tck}, {want_gp[4], want_gp[2:1]});
      for (int b = 0; b < 6; b++) begin
         p = i_bank_pll_src[3*b+:2];
         epd[b] = !off && sus && (i_bank_suspend_mask[b] || i_pll_suspend_mask[p]);
         eoe[b] = !off && !epd[b];
         if (eoe[b] && act && i_bank_oe_mask[b]) begin
            eoe[b] = i_bank_disable_level[2*b+1];
            elvl[b] = eoe[b] && i_bank_disable_level[2*b];
            if (eoe[b]) chk(o_bank_level[b], i_bank_disable_level[2*b]);
         end
         s = i_out_div_select[4*p+eg[2*p+:2]];
         if (md == 2'h0) chk(o_bank_div_set[b], s);
         if (md == 2'h0) chk(o_post_divider_value[10*b+:10], i_post_div_sets[20*b+10*s+:10]);
         if (md == 2'h1 && p == 0) chk(o_bank_div_set[b], i_out_div_select[q]);
      end
      chk(o_bank_power_down, epd);
      chk(o_bank_out_en, eoe);
      chk(o_bank_level, elvl);
      chk(o_bank_level_inv, 6'(~elvl ^ i_bank_invert));
   endtask : check_all
   // Power-up with nonzero pins, even disabled ones, and the mode pin high
   task automatic power_cycle;
      want_gp = 6'h3B;
      want_mode = 2'h3;
      want_shut = i_shutdown_polarity;
      repeat (5) @(posedge i_clock);
      #1 i_rst = 1'b1;
      repeat (4) @(posedge i_clock);
      #1 i_rst = 1'b0;
      lat = 5'h1B;
   endtask : power_cycle
   initial begin
      seed = 32'h2471;
      n_errors = 0;
      check_count = 0;
      {i_rst, hold_low, want_mode, i_gp_in_enable} = {2'h3, 2'h1, 6'h3F};
      {want_gp, want_shut, i_manual_freq_select, i_shutdown_polarity, lat} = '0;
      {i_global_off_function, i_primary_ref_select, i_lock_lost_flag, i_ref_lost_flag} = '0;
      {i_scan_tdo, i_pll_locked, i_bank_oe_mask, i_bank_suspend_mask, i_bank_invert} = '0;
      {i_bank_disable_level, i_out_div_select, i_pll_suspend_mask, i_bank_pll_src} = '0;
      i_post_div_sets = '0;
      ce = 1'b1;
      repeat (2) @(posedge i_clock);
      #1 i_rst = 1'b0;
      hold_low = 1'b0;
      for (k = 0; k < 48; k++) begin
         @(posedge i_clock);
         #1;
         if (k == 24) power_cycle;
         else if (k == 30) begin
            // Only pins move while frozen, so nothing inside may follow them
            frozen = {o_mode, o_pll2_sel, o_pll1_sel, o_pll0_sel, o_suspend, o_ref_select,
               o_bank_out_en};
            ce = 1'b0;
            want_gp = ~want_gp;
            want_mode = want_mode == 2'h1 ? 2'h0 : 2'h1;
         end else randomize_inputs;
         // Leaving programming mode for per-PLL mode with the pins driven to the latched configuration and input 5 low
         if (k == 25) {want_mode, i_manual_freq_select, i_gp_in_enable, want_gp} =
            {3'h2, 6'h3F, 1'b0, lat};
         repeat (8) @(posedge i_clock);
         #2;
         if (k == 30) chk(frozen, {o_mode, o_pll2_sel, o_pll1_sel, o_pll0_sel, o_suspend,
            o_ref_select, o_bank_out_en});
         else check_all;
      end
      tally_and_finish;
   end
endmodule : test_multipurpose_pin_mode_and_output_gating
bind mpg_top mpg_props #(.NUM_BANK(NUM_BANK)) u_mpg_props (.i_clock, .i_rst,
   .i_ref_lost_flag, .i_lock_lost_flag, .i_scan_tdo, .i_global_off_function,
   .i_shutdown_oe_pin, .i_shutdown_polarity, .i_pll_suspend_mask, .i_bank_oe_mask, .o_mode,
   .o_gp_out_0, .o_gp_out_1, .o_prog_allowed, .o_osc_off, .o_suspend, .o_pll_power_down,
   .o_bank_power_down, .o_bank_out_en);
`default_nettype wire
